/* File: src/lspc_top.sv */
// login service parameter codec: apb registers, builder, parser, interrupt
//
// Behaviour
// RULE1 - payload order: command, common, port name, node name, four classes, vendor, reserved
// RULE2 - services field and 116 reserved bytes appear only with the length flag set
// RULE3 - word 1 bit 16 picks a 128 or 256 byte payload both ways
// RULE4 - word 0 holds highest version, lowest version, then buffer credit
// RULE5 - versions 00-09, 10 and 20 are valid; all other codes are reserved
// RULE6 - word 1 low half is the largest accepted receive data field
// RULE7 - receive sizes below 256, above 2112 or not word multiples are invalid
// RULE8 - fabric login: word 1 bits 31-30, 26-17, words 2 and 3 are zero
// RULE9 - word 1 bits 29, 28, 27 carry vendor, port-type and alternate credit
// RULE10 - word 3 timeout counts only in point-to-point port login
// RULE11 - port login word 1 bits 31-28, 27 and 22 carry feature flags
// RULE12 - port login word 1 bit 26 picks millisecond or nanosecond timeout steps
// RULE13 - parser flags reserved versions and bad sizes so login can be refused
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module lspc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit payload stream
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_data,
  output logic tx_last,
  // receive payload stream
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic rx_last,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [9:0] ctrl, next_ctrl;
  logic [31:0] cmd, next_cmd;
  logic [31:0] cw0, next_cw0;
  logic [15:0] rxsz, next_rxsz;
  logic [31:0] edtov, next_edtov;
  logic [31:0] name [lspc_pkg::NAME_WORDS];
  logic [31:0] next_name [lspc_pkg::NAME_WORDS];
  logic [2:0] status, next_status;
  logic [2:0] mask, next_mask;
  logic [31:0] next_prdata, rd_data;
  logic [31:0] tx_cw1, tx_cw3;
  logic [127:0] names;
  logic wr_en, rd_setup, go, tx_busy, tx_done, rx_done;
  logic [5:0] tx_word_idx;
  logic [31:0] rx_cw0, rx_cw1, rx_edtov;
  logic [3:0] rx_err;
  logic [2:0] events, clr_bits;

  // address is a word inside the map
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= lspc_pkg::A_RXERR);
  endfunction : addr_ok

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states: read data is flopped in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign wr_en = psel && penable && pwrite && addr_ok(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign go = wr_en && (paddr == lspc_pkg::A_CTRL) && pwdata[lspc_pkg::C_GO];
  assign names = {name[0], name[1], name[2], name[3]};

  // read mux; unmapped words read zero
  always_comb
  begin
    rd_data = 32'h0;
    case (paddr)
      lspc_pkg::A_CTRL: rd_data = {tx_busy, 21'h0, ctrl};
      lspc_pkg::A_CMD: rd_data = cmd;
      lspc_pkg::A_CW0: rd_data = cw0;
      lspc_pkg::A_RXSZ: rd_data = {16'h0, rxsz};
      lspc_pkg::A_EDTOV: rd_data = edtov;
      lspc_pkg::A_STATUS: rd_data = {29'h0, status};
      lspc_pkg::A_MASK: rd_data = {29'h0, mask};
      lspc_pkg::A_RXCW0: rd_data = rx_cw0;
      lspc_pkg::A_RXCW1: rd_data = rx_cw1;
      lspc_pkg::A_RXEDTOV: rd_data = rx_edtov;
      lspc_pkg::A_RXERR: rd_data = {28'h0, rx_err};
      default:
      begin
        for (int i = 0; i < lspc_pkg::NAME_WORDS; i++)
          if (paddr == lspc_pkg::A_NAME0 + 8'(4 * i))
            rd_data = name[i];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register file and interrupt state
  // ----------------------------------------------------------------
  // events and the bits that a status read reported
  assign events = {rx_done && (rx_err != 4'h0), rx_done, tx_done};
  // only bits returned to software are cleared, so an event during the read survives
  assign clr_bits = (psel && penable && !pwrite && (paddr == lspc_pkg::A_STATUS)) ?
    prdata[2:0] : 3'h0;

  // next register values
  always_comb
  begin
    next_ctrl = ctrl;
    next_cmd = cmd;
    next_cw0 = cw0;
    next_rxsz = rxsz;
    next_edtov = edtov;
    next_mask = mask;
    next_name = name;
    next_prdata = rd_setup ? rd_data : prdata;
    next_status = (status & ~clr_bits) | events;
    if (wr_en)
    begin
      case (paddr)
        lspc_pkg::A_CTRL:
        begin
          next_ctrl = pwdata[9:0];
          next_ctrl[lspc_pkg::C_GO] = 1'b0;
        end
        lspc_pkg::A_CMD: next_cmd = pwdata;
        lspc_pkg::A_CW0: next_cw0 = pwdata; // see RULE4
        lspc_pkg::A_RXSZ: next_rxsz = pwdata[15:0]; // see RULE6
        lspc_pkg::A_EDTOV: next_edtov = pwdata;
        lspc_pkg::A_MASK: next_mask = pwdata[2:0];
        default:
        begin
          for (int i = 0; i < lspc_pkg::NAME_WORDS; i++)
            if (paddr == lspc_pkg::A_NAME0 + 8'(4 * i))
              next_name[i] = pwdata;
        end
      endcase
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= lspc_pkg::RST_CTRL;
      cmd <= lspc_pkg::RST_WORD;
      cw0 <= lspc_pkg::RST_CW0;
      rxsz <= lspc_pkg::RST_RXSZ;
      edtov <= lspc_pkg::RST_WORD;
      mask <= lspc_pkg::RST_IRQ;
      status <= lspc_pkg::RST_IRQ;
      prdata <= lspc_pkg::RST_WORD;
      for (int i = 0; i < lspc_pkg::NAME_WORDS; i++)
        name[i] <= lspc_pkg::RST_WORD;
    end
    else
    begin
      ctrl <= next_ctrl;
      cmd <= next_cmd;
      cw0 <= next_cw0;
      rxsz <= next_rxsz;
      edtov <= next_edtov;
      mask <= next_mask;
      status <= next_status;
      prdata <= next_prdata;
      name <= next_name;
    end
  end

  assign irq = (status & mask) != 3'h0;

  // ----------------------------------------------------------------
  // common parameter words for the builder
  // ----------------------------------------------------------------
  // reserved positions stay zero because the word starts cleared
  always_comb
  begin
    tx_cw1 = 32'h0;
    tx_cw1[15:0] = rxsz; // see RULE6
    tx_cw1[lspc_pkg::W1_P] = ctrl[lspc_pkg::C_LONG]; // see RULE3
    tx_cw1[lspc_pkg::W1_VV] = ctrl[lspc_pkg::C_VV]; // see RULE9
    tx_cw1[lspc_pkg::W1_NPF] = ctrl[lspc_pkg::C_NPF];
    tx_cw1[lspc_pkg::W1_ALT] = ctrl[lspc_pkg::C_ALT];
    if (ctrl[lspc_pkg::C_PLOGI])
    begin
      tx_cw1[lspc_pkg::W1_CONT] = ctrl[lspc_pkg::C_CONT]; // see RULE11
      tx_cw1[lspc_pkg::W1_RAND] = ctrl[lspc_pkg::C_RAND];
      tx_cw1[lspc_pkg::W1_DSX] = ctrl[lspc_pkg::C_DSX];
      tx_cw1[lspc_pkg::W1_EDNS] = ctrl[lspc_pkg::C_EDNS]; // see RULE12
    end
  end
  // fabric login carries no timeout word; see RULE8
  assign tx_cw3 = ctrl[lspc_pkg::C_PLOGI] ? edtov : 32'h0; // see RULE10

  // ----------------------------------------------------------------
  // builder and parser
  // ----------------------------------------------------------------
  // a start while busy is dropped; software polls busy or waits for the tx event
  lspc_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .start(go),
    .long_pl(pwdata[lspc_pkg::C_LONG]), // see RULE2
    .cmd(cmd),
    .cw0(cw0),
    .cw1(tx_cw1),
    .cw3(tx_cw3),
    .names(names), // see RULE1
    .busy(tx_busy),
    .done(tx_done),
    .word_idx(tx_word_idx),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_data(tx_data),
    .tx_last(tx_last)
  );

  lspc_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .port_login(ctrl[lspc_pkg::C_PLOGI]),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_last(rx_last),
    .rx_cw0(rx_cw0),
    .rx_cw1(rx_cw1),
    .rx_edtov(rx_edtov),
    .rx_err(rx_err),
    .rx_done(rx_done)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic acc;
  logic [6:0] sent;
  logic long_seen;
  assign acc = tx_valid && tx_ready;
  // helper: words accepted in this frame and the length chosen at its start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sent <= 7'h00;
      long_seen <= 1'b0;
    end
    else
    begin
      sent <= (go && !tx_busy) ? 7'h00 : (acc ? sent + 7'h01 : sent);
      long_seen <= (go && !tx_busy) ? pwdata[lspc_pkg::C_LONG] : long_seen;
    end
  end

  a_frame_length: assert property (tx_done |-> sent == (long_seen ? 7'd63 : 7'd31)) // see RULE2
    else $error("payload length does not match the length flag");
  a_name_order: assert property (acc && tx_word_idx == 6'h05 |-> tx_data == name[0]) // see RULE1
    else $error("port name not at payload word 5");
  a_version_word: assert property (acc && tx_word_idx == 6'h01 |->
    tx_data[31:24] == cw0[31:24] && tx_data[23:16] == cw0[23:16] &&
    tx_data[15:0] == cw0[15:0]) // see RULE4
    else $error("version range or credit misplaced in word 0");
  a_size_field: assert property (acc && tx_word_idx == 6'h02 |->
    tx_data[15:0] == rxsz && tx_data[16] == long_seen) // see RULE3
    else $error("size or length flag wrong in word 1");
  a_fabric_reserved: assert property (acc && !ctrl[1] &&
    (tx_word_idx == 6'h03 || tx_word_idx == 6'h04) |-> tx_data == 32'h0) // see RULE8
    else $error("fabric login reserved word not zero");
  a_fabric_flags: assert property (acc && !ctrl[1] && tx_word_idx == 6'h02 |->
    tx_data[31:30] == 2'b00 && tx_data[26:17] == 10'h000 &&
    tx_data[29:27] == {ctrl[4], ctrl[5], ctrl[6]}) // see RULE9
    else $error("fabric login feature bits wrong");
  a_port_flags: assert property (acc && ctrl[1] && tx_word_idx == 6'h02 |->
    tx_data[31:27] == {ctrl[7], ctrl[8], ctrl[4], ctrl[5], ctrl[6]} &&
    tx_data[22] == ctrl[9]) // see RULE11
    else $error("port login feature bits wrong");
  a_timeout_unit: assert property (acc && ctrl[1] && tx_word_idx == 6'h02 |->
    tx_data[26] == ctrl[3]) // see RULE12
    else $error("timeout resolution bit wrong");
  a_timeout_word: assert property (acc && tx_word_idx == 6'h04 |->
    tx_data == (ctrl[1] ? edtov : 32'h0)) // see RULE10
    else $error("timeout word wrong for login kind");
  a_rx_version: assert property (rx_done |->
    rx_err[0] == !(rx_cw0[31:24] <= 8'h09 || rx_cw0[31:24] == 8'h10 ||
    rx_cw0[31:24] == 8'h20)) // see RULE5
    else $error("highest version check wrong");
  a_rx_size: assert property (rx_done |-> rx_err[2] ==
    (rx_cw1[15:0] < 16'd256 || rx_cw1[15:0] > 16'd2112 || rx_cw1[1:0] != 2'b00)) // see RULE7
    else $error("receive size check wrong");
  a_rx_error_irq: assert property (rx_done && rx_err != 4'h0 |=> status[2] &&
    (!mask[2] || irq)) // see RULE13
    else $error("receive error not reported");

  c_short_frame: cover property (tx_done && !long_seen);
  c_long_frame: cover property (tx_done && long_seen);
  c_rx_clean: cover property (rx_done && rx_err == 4'h0);
  c_rx_error: cover property (rx_done && rx_err != 4'h0 ##1 irq);
endmodule : lspc_top

/* File: pkg/lspc_pkg.sv */
// constants, field layout and decode helpers for the login parameter codec
package lspc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_CW0 = 8'h08;
  localparam logic [7:0] A_RXSZ = 8'h0c;
  localparam logic [7:0] A_EDTOV = 8'h10;
  localparam logic [7:0] A_NAME0 = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam logic [7:0] A_MASK = 8'h28;
  localparam logic [7:0] A_RXCW0 = 8'h2c;
  localparam logic [7:0] A_RXCW1 = 8'h30;
  localparam logic [7:0] A_RXEDTOV = 8'h34;
  localparam logic [7:0] A_RXERR = 8'h38;
  localparam int NAME_WORDS = 4;
  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  localparam int C_GO = 0;
  localparam int C_PLOGI = 1;
  localparam int C_LONG = 2;
  localparam int C_EDNS = 3;
  localparam int C_VV = 4;
  localparam int C_NPF = 5;
  localparam int C_ALT = 6;
  localparam int C_CONT = 7;
  localparam int C_RAND = 8;
  localparam int C_DSX = 9;
  localparam int C_BUSY = 31;
  // status bits and receive error bits
  localparam int S_TX = 0;
  localparam int S_RX = 1;
  localparam int S_ERR = 2;
  localparam int E_HI = 0;
  localparam int E_LO = 1;
  localparam int E_SIZE = 2;
  localparam int E_LEN = 3;
  // ----------------------------------------------------------------
  // common parameter word 1 feature bits
  // ----------------------------------------------------------------
  localparam int W1_CONT = 31;
  localparam int W1_RAND = 30;
  localparam int W1_VV = 29;
  localparam int W1_NPF = 28;
  localparam int W1_ALT = 27;
  localparam int W1_EDNS = 26;
  localparam int W1_DSX = 22;
  localparam int W1_P = 16;
  // ----------------------------------------------------------------
  // payload word layout (word index from command code)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CMD = 6'h00;
  localparam logic [5:0] IDX_CW0 = 6'h01;
  localparam logic [5:0] IDX_CW1 = 6'h02;
  localparam logic [5:0] IDX_CW2 = 6'h03;
  localparam logic [5:0] IDX_CW3 = 6'h04;
  localparam logic [5:0] IDX_PNAME = 6'h05;
  localparam logic [5:0] IDX_NNAME = 6'h07;
  localparam logic [5:0] LAST_SHORT = 6'h1f;
  localparam logic [5:0] LAST_LONG = 6'h3f;
  // ----------------------------------------------------------------
  // limits, version codes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SIZE_MIN = 16'h0100;
  localparam logic [15:0] SIZE_MAX = 16'h0840;
  localparam logic [7:0] VER_PRE_MAX = 8'h09;
  localparam logic [7:0] VER_ED2 = 8'h10;
  localparam logic [7:0] VER_ED3 = 8'h20;
  localparam logic [9:0] RST_CTRL = 10'h000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_CW0 = 32'h2020_0001;
  localparam logic [15:0] RST_RXSZ = 16'h0840;
  localparam logic [2:0] RST_IRQ = 3'h0;

  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} lspc_tx_state_e;

  // version code falls in one of the reserved ranges
  function automatic logic ver_reserved(input logic [7:0] v);
    ver_reserved = !((v <= VER_PRE_MAX) || (v == VER_ED2) || (v == VER_ED3));
  endfunction : ver_reserved

  // receive data field size out of range or not a whole number of words
  function automatic logic size_bad(input logic [15:0] s);
    size_bad = (s < SIZE_MIN) || (s > SIZE_MAX) || (s[1:0] != 2'b00);
  endfunction : size_bad
endpackage : lspc_pkg

/* File: src/lspc_tx.sv */
// payload builder: streams one login payload word by word
`timescale 1ns/1ps
module lspc_tx (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frame content
  input wire logic start,
  input wire logic long_pl,
  input wire logic [31:0] cmd,
  input wire logic [31:0] cw0,
  input wire logic [31:0] cw1,
  input wire logic [31:0] cw3,
  input wire logic [127:0] names,
  // status
  output logic busy,
  output logic done,
  output logic [5:0] word_idx,
  // link
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_data,
  output logic tx_last
);
  lspc_pkg::lspc_tx_state_e state, next_state;
  logic [5:0] next_idx;
  logic [31:0] next_data;
  logic long_q, next_long;

  // word at a payload position; class blocks, vendor and extension send zero
  function automatic logic [31:0] word_at(input logic [5:0] i);
    case (i)
      lspc_pkg::IDX_CMD: word_at = cmd;
      lspc_pkg::IDX_CW0: word_at = cw0;
      lspc_pkg::IDX_CW1: word_at = cw1;
      lspc_pkg::IDX_CW3: word_at = cw3;
      lspc_pkg::IDX_PNAME: word_at = names[127:96];
      lspc_pkg::IDX_PNAME + 6'h01: word_at = names[95:64];
      lspc_pkg::IDX_NNAME: word_at = names[63:32];
      lspc_pkg::IDX_NNAME + 6'h01: word_at = names[31:0];
      default: word_at = 32'h0;
    endcase
  endfunction : word_at

  assign busy = (state == lspc_pkg::TX_SEND);
  assign tx_valid = busy;
  // frame ends at 32 or 64 words depending on the latched length flag
  assign tx_last = busy && (word_idx == (long_q ? lspc_pkg::LAST_LONG : lspc_pkg::LAST_SHORT));
  assign done = tx_valid && tx_ready && tx_last;

  // next state; length is latched at start so a mid-frame write cannot cut it
  always_comb
  begin
    next_state = state;
    next_idx = word_idx;
    next_data = tx_data;
    next_long = long_q;
    case (state)
      lspc_pkg::TX_IDLE:
      begin
        if (start)
        begin
          next_state = lspc_pkg::TX_SEND;
          next_idx = lspc_pkg::IDX_CMD;
          next_data = word_at(lspc_pkg::IDX_CMD);
          next_long = long_pl;
        end
      end
      lspc_pkg::TX_SEND:
      begin
        if (tx_ready && tx_last)
          next_state = lspc_pkg::TX_IDLE;
        else if (tx_ready)
        begin
          next_idx = word_idx + 6'h01;
          next_data = word_at(word_idx + 6'h01);
        end
      end
      default: next_state = lspc_pkg::TX_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= lspc_pkg::TX_IDLE;
      word_idx <= 6'h00;
      tx_data <= lspc_pkg::RST_WORD;
      long_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      word_idx <= next_idx;
      tx_data <= next_data;
      long_q <= next_long;
    end
  end
endmodule : lspc_tx

/* File: src/lspc_rx.sv */
// payload parser: captures common parameters and checks them at frame end
`timescale 1ns/1ps
module lspc_rx (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mode
  input wire logic port_login,
  // link
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic rx_last,
  // results
  output logic [31:0] rx_cw0,
  output logic [31:0] rx_cw1,
  output logic [31:0] rx_edtov,
  output logic [3:0] rx_err,
  output logic rx_done
);
  logic [6:0] idx, next_idx;
  logic [31:0] next_cw0, next_cw1, next_edtov;
  logic [3:0] next_err;
  logic next_done;
  logic [6:0] want;

  // capture by position; checks use this word's value when it is the last
  always_comb
  begin
    next_idx = idx;
    next_cw0 = rx_cw0;
    next_cw1 = rx_cw1;
    next_edtov = rx_edtov;
    next_err = rx_err;
    next_done = 1'b0;
    want = 7'h00;
    if (rx_valid)
    begin
      // index saturates so an overlong frame cannot wrap into a good length
      next_idx = (idx == 7'h7f) ? idx : idx + 7'h01;
      if (idx == {1'b0, lspc_pkg::IDX_CW0})
        next_cw0 = rx_data;
      if (idx == {1'b0, lspc_pkg::IDX_CW1})
        next_cw1 = rx_data;
      if (idx == {1'b0, lspc_pkg::IDX_CW3})
        next_edtov = port_login ? rx_data : 32'h0; // see RULE10
      if (rx_last)
      begin
        next_idx = 7'h00;
        next_done = 1'b1;
        want = next_cw1[lspc_pkg::W1_P] ? {1'b0, lspc_pkg::LAST_LONG} :
          {1'b0, lspc_pkg::LAST_SHORT}; // see RULE3
        next_err[lspc_pkg::E_HI] = lspc_pkg::ver_reserved(next_cw0[31:24]); // see RULE13
        next_err[lspc_pkg::E_LO] = lspc_pkg::ver_reserved(next_cw0[23:16]); // see RULE5
        next_err[lspc_pkg::E_SIZE] = lspc_pkg::size_bad(next_cw1[15:0]); // see RULE7
        next_err[lspc_pkg::E_LEN] = (idx != want); // see RULE2
      end
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx <= 7'h00;
      rx_cw0 <= lspc_pkg::RST_WORD;
      rx_cw1 <= lspc_pkg::RST_WORD;
      rx_edtov <= lspc_pkg::RST_WORD;
      rx_err <= 4'h0;
      rx_done <= 1'b0;
    end
    else
    begin
      idx <= next_idx;
      rx_cw0 <= next_cw0;
      rx_cw1 <= next_cw1;
      rx_edtov <= next_edtov;
      rx_err <= next_err;
      rx_done <= next_done;
    end
  end
endmodule : lspc_rx

/* File: tb/lspc_link_model.sv */
// far-side link model: sinks transmitted payloads and sources received ones
`timescale 1ns/1ps
module lspc_link_model (
  // clock
  input wire logic pclk,
  // payload from the codec
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  // payload to the codec
  output logic rx_valid,
  output logic [31:0] rx_data,
  output logic rx_last
);
  logic [31:0] cap [0:63];
  logic [5:0] wi = 6'h00;
  logic [5:0] nlast = 6'h00;
  logic slow = 1'b0;
  int frames = 0;
  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 32'h0000_0000;
    rx_last = 1'b0;
  end
  // -------------------------------------------------------------
  // sink: slow mode stalls every other cycle to test holding
  // -------------------------------------------------------------
  always @(posedge pclk)
  begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    if (tx_valid && tx_ready)
    begin
      cap[wi] <= tx_data;
      wi <= tx_last ? 6'h00 : wi + 6'h01;
      if (tx_last)
      begin
        nlast <= wi;
        frames <= frames + 1;
      end
    end
  end
  // source: one word a cycle, data inverted once released
  task automatic send(input logic [31:0] w1, input logic [31:0] w2, input int n);
    for (int k = 0; k < n; k++)
    begin
      rx_valid <= 1'b1;
      rx_data <= k == 1 ? w1 : k == 2 ? w2 : k == 4 ? 32'h0000_0064 : 32'h0200_0000;
      rx_last <= (k == n - 1);
      @(posedge pclk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send
endmodule : lspc_link_model

/* File: tb/testbench.sv */
// self-checking bench for the login parameter codec
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, tx_data, rx_data, q, w1, w2, ex;
  logic pready, pslverr, tx_valid, tx_ready, tx_last, rx_valid, rx_last, irq, err;
  logic [3:0] e;
  int fails = 0;
  int tests_run = 0;
  int f;
  // receive cases: high, low version, size, length flag, word count
  logic [7:0] hv [6] = '{8'h20, 8'h0a, 8'h20, 8'h21, 8'h10, 8'h09};
  logic [7:0] lv [6] = '{8'h10, 8'h09, 8'h11, 8'h00, 8'h20, 8'h00};
  logic [15:0] sz [6] = '{16'h0840, 16'h0100, 16'h00fc, 16'h0842, 16'h0844, 16'h083c};
  logic pl [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int nw [6] = '{32, 64, 32, 32, 32, 64};
  always #4 pclk = ~pclk;
  lspc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .irq(irq));
  lspc_link_model link (.pclk(pclk), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last));
  // -------------------------------------------------------------
  // verdict, reserved-code reference, apb transfer
  // -------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  function automatic logic resv(input logic [7:0] v);
    resv = !(v <= 8'h09 || v == 8'h10 || v == 8'h20);
  endfunction : resv
  // one transfer; an extra edge after release keeps drivers single per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, lspc_pkg::A_CW0, 0); `CHK("cw0 reset", 32'h2020_0001, q)
    apb(0, lspc_pkg::A_RXSZ, 0); `CHK("rxsz reset", 32'h0000_0840, q)
    apb(0, 8'h3c, 0); `CHK("unmapped err", 1'b1, err)
    apb(1, lspc_pkg::A_CMD, 32'h0400_0000);
    apb(1, lspc_pkg::A_CW0, 32'h2010_0005);
    apb(1, lspc_pkg::A_RXSZ, 32'h0000_0800);
    apb(1, lspc_pkg::A_EDTOV, 32'h0000_07d0);
    for (int i = 0; i < 4; i++)
      apb(1, lspc_pkg::A_NAME0 + 8'(4 * i), 32'ha000_0000 + i);
    // fabric short frame with every flag set, then port login long with stalls
    for (int m = 0; m < 2; m++)
    begin
      link.slow = m[0];
      f = link.frames;
      apb(1, lspc_pkg::A_CTRL, m ? 32'h0000_038f : 32'h0000_03f9);
      for (int n = 0; n < 500 && link.frames == f; n++)
        @(posedge pclk);
      `CHK("frame seen", 1'b1, link.frames != f)
      `CHK("last index", m ? 6'd63 : 6'd31, link.nlast)
      w2 = m ? 32'hc441_0800 : 32'h3800_0800;
      for (int k = 0; k <= (m ? 63 : 31); k++)
      begin
        ex = k == 0 ? 32'h0400_0000 : k == 1 ? 32'h2010_0005 : k == 2 ? w2 : 32'h0;
        if (k == 4 && m == 1)
          ex = 32'h0000_07d0;
        if (k >= 5 && k <= 8)
          ex = 32'ha000_0000 + k - 5;
        `CHK("tx word", ex, link.cap[k])
      end
      `CHK("irq masked", m[0], irq)
      apb(1, lspc_pkg::A_MASK, 32'h7);
      `CHK("irq", 1'b1, irq)
      apb(0, lspc_pkg::A_STATUS, 0); `CHK("tx status", 32'h1, q)
      `CHK("irq cleared", 1'b0, irq)
    end
    // receive table, odd cases in port login mode
    for (int c = 0; c < 6; c++)
    begin
      apb(1, lspc_pkg::A_CTRL, {30'h0, c[0], 1'b0});
      w1 = {hv[c], lv[c], 16'h0008};
      w2 = {15'h0, pl[c], sz[c]};
      link.send(w1, w2, nw[c]);
      repeat (3) @(posedge pclk);
      e[0] = resv(hv[c]);
      e[1] = resv(lv[c]);
      e[2] = sz[c] < 16'd256 || sz[c] > 16'd2112 || sz[c][1:0] != 2'b00;
      e[3] = nw[c] != (pl[c] ? 64 : 32);
      apb(0, lspc_pkg::A_RXCW0, 0); `CHK("rx word0", w1, q)
      apb(0, lspc_pkg::A_RXCW1, 0); `CHK("rx word1", w2, q)
      apb(0, lspc_pkg::A_RXEDTOV, 0); `CHK("rx timeout", c[0] ? 32'h64 : 32'h0, q)
      apb(0, lspc_pkg::A_RXERR, 0); `CHK("rx error", {28'h0, e}, q)
      apb(0, lspc_pkg::A_STATUS, 0); `CHK("rx status", {29'h0, |e, 2'b10}, q)
    end
    give_verdict();
  end
endmodule : testbench
